// ===== common/fram_ctrl_pkg.sv
// Constants and types shared by the nonvolatile array access controller
// Contract
// - Zero waits to 8 MHz, waits above
// - Direct reads and writes, no erase
// - Any bit overwritten alone, no erase
// - Every read followed by transparent write-back
// - Started write-back always runs to completion
// - Read-only segment blocks writes, raises error
// - Three privilege sets, run-time movable boundaries
// - Boundaries only on 4KB multiples
package fram_ctrl_pkg;

    // -------------------------------------------------------------
    // Clocking and wait states
    // -------------------------------------------------------------
    localparam int SYS_CLK_MHZ     = 100;
    localparam int ARRAY_MAX_MHZ   = 8;
    // Least waits so that one access spans one array period, rounded up
    localparam int MIN_WAITS_INT   = (SYS_CLK_MHZ + ARRAY_MAX_MHZ - 1) / ARRAY_MAX_MHZ - 1;
    localparam int WAIT_W          = 4;
    localparam logic [WAIT_W-1:0] MIN_WAITS  = MIN_WAITS_INT[WAIT_W-1:0];
    localparam logic [WAIT_W-1:0] WAITS_RST  = 4'h0;

    // -------------------------------------------------------------
    // Control word layout
    // -------------------------------------------------------------
    localparam int CTRL_W          = 16;
    localparam int CTRL_PW_POS     = 8;
    localparam int CTRL_PW_W       = 8;
    localparam logic [CTRL_PW_W-1:0] CTRL_PASSWORD = 8'hA5;
    localparam int CTRL_WAIT_POS   = 4;

    // -------------------------------------------------------------
    // Array geometry and segment guard
    // -------------------------------------------------------------
    localparam int ADDR_W          = 15;
    localparam int DATA_W          = 16;
    localparam int BLOCK_SHIFT     = 12;
    localparam int BLK_W           = ADDR_W - BLOCK_SHIFT;

    typedef enum logic [1:0] {
        PERM_RO,
        PERM_RW,
        PERM_RX
    } seg_perm_t;

    localparam logic [1:0] PERM_RST = 2'h1;

endpackage : fram_ctrl_pkg

// ===== logic/fram_cell_array.sv
// Ferroelectric word array with destructive sensing and bit-masked write
`timescale 1ns/1ps
module fram_cell_array #(
    parameter int DW     = 16,
    parameter int AW     = 14
) (
    input  wire logic          clk_sys_i,
    input  wire logic          rst_n_i,
    input  wire logic          ce_i,
    input  wire logic          rd_i,
    input  wire logic          wr_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [DW-1:0] mask_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rdata_d;

    always_comb begin
        rdata_d = rdata_o;
        if (rd_i) begin
            rdata_d = mem[addr_i];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= rdata_d;
        end
    end

    // -------------------------------------------------------------
    // Cells: sensing wipes the word, writes touch only masked bits
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (ce_i && wr_i) begin
            mem[addr_i] <= (mem[addr_i] & ~mask_i) | (wdata_i & mask_i);
        end else if (ce_i && rd_i) begin
            mem[addr_i] <= '0;
        end
    end

endmodule : fram_cell_array

// ===== logic/fram_access_controller.sv
// Access controller: wait states, write-back after sensing, segment guard
`timescale 1ns/1ps
module fram_access_controller (
    input  wire logic                                clk_sys_i,
    input  wire logic                                resetn_i,
    input  wire logic                                ce_i,
    input  wire logic                                pwr_fail_i,
    input  wire logic                                req_i,
    input  wire logic                                we_i,
    input  wire logic                                fetch_i,
    input  wire logic [fram_ctrl_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [fram_ctrl_pkg::DATA_W-1:0]    wdata_i,
    input  wire logic [fram_ctrl_pkg::DATA_W-1:0]    bit_mask_i,
    input  wire logic                                ctrl_wr_i,
    input  wire logic [fram_ctrl_pkg::CTRL_W-1:0]    array_ctrl_word0_i,
    input  wire logic                                guard_en_i,
    input  wire logic [fram_ctrl_pkg::BLK_W-1:0]     seg_bound1_i,
    input  wire logic [fram_ctrl_pkg::BLK_W-1:0]     seg_bound2_i,
    input  wire fram_ctrl_pkg::seg_perm_t            seg0_perm_i,
    input  wire fram_ctrl_pkg::seg_perm_t            seg1_perm_i,
    input  wire fram_ctrl_pkg::seg_perm_t            seg2_perm_i,
    input  wire logic                                viol_clr_i,
    output logic                                     ack_o,
    output logic                                     err_o,
    output logic                                     busy_o,
    output logic [fram_ctrl_pkg::DATA_W-1:0]         rdata_o,
    output logic                                     viol_flag_o,
    output logic [fram_ctrl_pkg::WAIT_W-1:0]         wait_state_count_o
);
    import fram_ctrl_pkg::*;

    localparam int WORD_AW = ADDR_W - 1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_SENSE
    } acc_state_t;

    // -------------------------------------------------------------
    // Reset release
    // -------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // -------------------------------------------------------------
    // Control word and violation flag
    // -------------------------------------------------------------
    logic [WAIT_W-1:0] waits_q;
    logic [WAIT_W-1:0] waits_d;
    logic              viol_q;
    logic              viol_d;
    logic              pw_ok;
    logic              viol_evt;

    assign pw_ok = array_ctrl_word0_i[CTRL_PW_POS +: CTRL_PW_W] == CTRL_PASSWORD;

    always_comb begin
        waits_d = waits_q;
        viol_d  = viol_q;
        if (ctrl_wr_i && pw_ok) begin
            waits_d = array_ctrl_word0_i[CTRL_WAIT_POS +: WAIT_W];
        end
        if (viol_clr_i) begin
            viol_d = 1'b0;
        end
        // Set beats clear so a violation in the clear cycle survives
        if (viol_evt) begin
            viol_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            waits_q <= WAITS_RST;
            viol_q  <= 1'b0;
        end else if (ce_i) begin
            waits_q <= waits_d;
            viol_q  <= viol_d;
        end
    end

    // -------------------------------------------------------------
    // Segment guard
    // -------------------------------------------------------------
    logic [BLK_W-1:0] req_blk;
    seg_perm_t        req_perm;
    logic             req_denied;

    // Block index only: finer boundaries cannot be expressed
    assign req_blk = addr_i[ADDR_W-1:BLOCK_SHIFT];

    always_comb begin
        if (req_blk < seg_bound1_i) begin
            req_perm = seg0_perm_i;
        end else if (req_blk < seg_bound2_i) begin
            req_perm = seg1_perm_i;
        end else begin
            req_perm = seg2_perm_i;
        end
        req_denied = 1'b0;
        if (guard_en_i) begin
            if (we_i) begin
                req_denied = req_perm != PERM_RW;
            end else if (fetch_i) begin
                req_denied = req_perm != PERM_RX;
            end
        end
    end

    // -------------------------------------------------------------
    // Access sequencer
    // -------------------------------------------------------------
    acc_state_t          state_q;
    acc_state_t          state_d;
    logic [WAIT_W-1:0]   cnt_q;
    logic [WAIT_W-1:0]   cnt_d;
    logic [WORD_AW-1:0]  addr_q;
    logic [WORD_AW-1:0]  addr_d;
    logic [DATA_W-1:0]   wdata_q;
    logic [DATA_W-1:0]   wdata_d;
    logic [DATA_W-1:0]   mask_q;
    logic [DATA_W-1:0]   mask_d;
    logic                we_q;
    logic                we_d;
    logic                ack_d;
    logic                err_d;
    logic [DATA_W-1:0]   rdata_d;
    logic                accept;
    logic                mem_rd;
    logic                mem_wr;
    logic [DATA_W-1:0]   mem_wdata;
    logic [DATA_W-1:0]   mem_mask;
    logic [DATA_W-1:0]   mem_rdata;
    logic [WAIT_W-1:0]   eff_waits;

    // Never run faster than the array, even before software programs it
    assign eff_waits = (waits_q < MIN_WAITS) ? MIN_WAITS : waits_q;
    // Power loss stops new work but never an access already taken
    assign accept    = (state_q == ST_IDLE) && req_i && !pwr_fail_i;
    assign viol_evt  = accept && req_denied;

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        addr_d    = addr_q;
        wdata_d   = wdata_q;
        mask_d    = mask_q;
        we_d      = we_q;
        ack_d     = 1'b0;
        err_d     = 1'b0;
        rdata_d   = rdata_o;
        mem_rd    = 1'b0;
        mem_wr    = 1'b0;
        mem_wdata = wdata_q;
        mem_mask  = mask_q;
        case (state_q)
            ST_IDLE: begin
                if (accept && req_denied) begin
                    ack_d = 1'b1;
                    err_d = 1'b1;
                end else if (accept) begin
                    addr_d  = addr_i[ADDR_W-1:1];
                    wdata_d = wdata_i;
                    mask_d  = bit_mask_i;
                    we_d    = we_i;
                    cnt_d   = eff_waits;
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else if (we_q) begin
                    mem_wr  = 1'b1;
                    ack_d   = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    mem_rd  = 1'b1;
                    state_d = ST_SENSE;
                end
            end
            ST_SENSE: begin
                // Restore in the same cycle the master gets its data
                mem_wr    = 1'b1;
                mem_wdata = mem_rdata;
                mem_mask  = '1;
                rdata_d   = mem_rdata;
                ack_d     = 1'b1;
                state_d   = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            addr_q  <= '0;
            wdata_q <= '0;
            mask_q  <= '0;
            we_q    <= 1'b0;
            ack_o   <= 1'b0;
            err_o   <= 1'b0;
            rdata_o <= '0;
        end else if (ce_i) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            mask_q  <= mask_d;
            we_q    <= we_d;
            ack_o   <= ack_d;
            err_o   <= err_d;
            rdata_o <= rdata_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            busy_o             <= 1'b0;
            viol_flag_o        <= 1'b0;
            wait_state_count_o <= WAITS_RST;
        end else if (ce_i) begin
            busy_o             <= state_d != ST_IDLE;
            viol_flag_o        <= viol_d;
            wait_state_count_o <= waits_d;
        end
    end

    fram_cell_array #(
        .DW      (DATA_W),
        .AW      (WORD_AW)
    ) u_cells (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .ce_i      (ce_i),
        .rd_i      (mem_rd),
        .wr_i      (mem_wr),
        .addr_i    (addr_q),
        .wdata_i   (mem_wdata),
        .mask_i    (mem_mask),
        .rdata_o   (mem_rdata)
    );

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    sequence s_read_issue;
        state_q == ST_WAIT && cnt_q == '0 && !we_q && ce_i;
    endsequence

    sequence s_sense;
        state_q == ST_SENSE && ce_i;
    endsequence

    AST_NO_EARLY_ACK: assert property (
        (accept && !req_denied && ce_i) |=> (!ack_o) [*8]
    ) else $error("Array access acknowledged before wait states elapsed");

    AST_READ_SENSE: assert property (
        s_read_issue ##1 s_sense |=> ack_o && rdata_o == $past(mem_rdata)
    ) else $error("Read data not returned after sensing");

    AST_WRITE_BACK: assert property (
        state_q == ST_SENSE |-> mem_wr && mem_wdata == mem_rdata && mem_mask == '1
    ) else $error("Sensed word not written back");

    AST_WB_UNDER_FAIL: assert property (
        (s_sense and pwr_fail_i) |=> state_q == ST_IDLE && ack_o
    ) else $error("Write-back interrupted by power loss");

    AST_RO_BLOCK: assert property (
        (accept && we_i && guard_en_i && req_perm == PERM_RO && ce_i)
            |=> err_o && ack_o && viol_flag_o && state_q == ST_IDLE
    ) else $error("Write into read-only segment not blocked");

    AST_VIOL_STICKY: assert property (
        (viol_flag_o && !viol_clr_i && ce_i) |=> viol_flag_o
    ) else $error("Violation flag dropped without clear");

    AST_BAD_PW: assert property (
        (ctrl_wr_i && !pw_ok && ce_i) |=> wait_state_count_o == $past(wait_state_count_o)
    ) else $error("Control write with wrong password took effect");

    AST_DIRECT_WRITE: assert property (
        (accept && we_i && !guard_en_i && ce_i) |-> ##[1:20] (ack_o && !err_o)
    ) else $error("Unguarded write not completed");

    AST_BIT_MASK: assert property (
        (mem_wr && state_q == ST_WAIT) |-> mem_mask == mask_q && mem_wdata == wdata_q
    ) else $error("Array write ignores caller bit mask");

endmodule : fram_access_controller

// ===== test/cpu_master_model.sv
// Processor-side model issuing array accesses and control word writes
`timescale 1ns/1ps
module cpu_master_model (
    input  wire logic                             clk_sys_i,
    input  wire logic                             ack_i,
    input  wire logic                             err_i,
    input  wire logic [fram_ctrl_pkg::DATA_W-1:0] rdata_i,
    output logic                                  req_o,
    output logic                                  we_o,
    output logic                                  fetch_o,
    output logic      [fram_ctrl_pkg::ADDR_W-1:0] addr_o,
    output logic      [fram_ctrl_pkg::DATA_W-1:0] wdata_o,
    output logic      [fram_ctrl_pkg::DATA_W-1:0] mask_o,
    output logic                                  ctrl_wr_o,
    output logic      [fram_ctrl_pkg::CTRL_W-1:0] ctrl_word_o
);
    import fram_ctrl_pkg::*;
    localparam int LAT_CAP = 40;

    initial begin
        req_o       = 1'b0;
        we_o        = 1'b0;
        fetch_o     = 1'b0;
        addr_o      = 15'h0000;
        wdata_o     = 16'h0000;
        mask_o      = 16'h0000;
        ctrl_wr_o   = 1'b0;
        ctrl_word_o = 16'h0000;
    end

    // ----------------------------------------
    // Control word and access cycles
    // ----------------------------------------
    // Called ahead of any clock raise, so waits are in place first
    task automatic set_ctrl(input logic [7:0] pw, input logic [3:0] w);
        @(posedge clk_sys_i);
        ctrl_wr_o   <= 1'b1;
        ctrl_word_o <= {pw, w, 4'h0};
        @(posedge clk_sys_i);
        ctrl_wr_o   <= 1'b0;
        ctrl_word_o <= ~{pw, w, 4'h0};
    endtask : set_ctrl

    // Request is a one-cycle pulse; qualifiers stand until the answer.
    // Latency counts edges from the launch edge, so a denial shows as 1.
    task automatic access(input logic w, input logic f, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] m,
                          output int lat, output logic [DATA_W-1:0] rd, output logic e);
        @(posedge clk_sys_i);
        req_o   <= 1'b1;
        we_o    <= w;
        fetch_o <= f;
        addr_o  <= a;
        wdata_o <= d;
        mask_o  <= m;
        lat = 0;
        do begin
            @(posedge clk_sys_i);
            req_o <= 1'b0;
            #1;
            lat++;
        end while (ack_i !== 1'b1 && lat < LAT_CAP);
        rd = rdata_i;
        e  = err_i;
        // Released lines show inverted data, never a stale copy
        @(posedge clk_sys_i);
        addr_o  <= ~a;
        wdata_o <= ~d;
        mask_o  <= ~m;
    endtask : access
endmodule : cpu_master_model

// ===== test/fram_access_controller_test.sv
// Self-checking bench for the array access controller
`timescale 1ns/1ps
module fram_access_controller_test;
    import fram_ctrl_pkg::*;
    localparam int WM = MIN_WAITS;
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, pwr_fail_i = 1'b0;
    logic guard_en_i = 1'b0, viol_clr_i = 1'b0;
    logic [BLK_W-1:0] seg_bound1_i = 3'h0, seg_bound2_i = 3'h0;
    seg_perm_t seg0_perm_i = PERM_RW, seg1_perm_i = PERM_RW, seg2_perm_i = PERM_RW;
    logic req_i, we_i, fetch_i, ctrl_wr_i, ack_o, err_o, busy_o, viol_flag_o, e;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, bit_mask_i, rdata_o, rdat;
    logic [CTRL_W-1:0] array_ctrl_word0_i;
    logic [WAIT_W-1:0] wait_state_count_o;
    int lat, cyc, n_fail, cmp_count;

    always #5 clk_sys_i = ~clk_sys_i;

    fram_access_controller DUT (.clk_sys_i, .resetn_i, .ce_i, .pwr_fail_i, .req_i, .we_i,
        .fetch_i, .addr_i, .wdata_i, .bit_mask_i, .ctrl_wr_i, .array_ctrl_word0_i,
        .guard_en_i, .seg_bound1_i, .seg_bound2_i, .seg0_perm_i, .seg1_perm_i,
        .seg2_perm_i, .viol_clr_i, .ack_o, .err_o, .busy_o, .rdata_o, .viol_flag_o,
        .wait_state_count_o);

    cpu_master_model cpu (.clk_sys_i, .ack_i(ack_o), .err_i(err_o), .rdata_i(rdata_o),
        .req_o(req_i), .we_o(we_i), .fetch_o(fetch_i), .addr_o(addr_i), .wdata_o(wdata_i),
        .mask_o(bit_mask_i), .ctrl_wr_o(ctrl_wr_i), .ctrl_word_o(array_ctrl_word0_i));

    // ----------------------------------------
    // Compare and access helpers
    // ----------------------------------------
    task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_b

    task automatic chk_lat(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            n_fail++;
            $display("Error %0t: latency %0d expected %0d", $time, got, exp);
        end
    endtask : chk_lat

    task automatic wr(input logic [14:0] a, input logic [15:0] d, input logic [15:0] m);
        cpu.access(1'b1, 1'b0, a, d, m, lat, rdat, e);
    endtask : wr

    task automatic rd(input logic [14:0] a, input logic f);
        cpu.access(1'b0, f, a, 16'h0000, 16'h0000, lat, rdat, e);
    endtask : rd

    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask : tick

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_waits();
        chk_w({12'h000, wait_state_count_o}, {12'h000, WAITS_RST});
        chk_b(viol_flag_o, 1'b0);
        cpu.set_ctrl(8'h5A, 4'h9);
        tick();
        chk_w({12'h000, wait_state_count_o}, 16'h0000);
        cpu.set_ctrl(CTRL_PASSWORD, 4'h3);
        tick();
        chk_w({12'h000, wait_state_count_o}, 16'h0003);
        wr(15'h0100, 16'hFFFF, 16'hFFFF);
        chk_lat(lat, WM + 2);
        cpu.set_ctrl(CTRL_PASSWORD, 4'hF);
        wr(15'h0102, 16'hAAAA, 16'hFFFF);
        chk_lat(lat, 17);
        rd(15'h0102, 1'b0);
        chk_lat(lat, 18);
        chk_w(rdat, 16'hAAAA);
        cpu.set_ctrl(CTRL_PASSWORD, 4'h0);
    endtask : t_waits

    task automatic t_bits();
        wr(15'h0100, 16'h0000, 16'h00F0);
        rd(15'h0100, 1'b0);
        chk_w(rdat, 16'hFF0F);
        chk_lat(lat, WM + 3);
        rd(15'h0100, 1'b0);
        chk_w(rdat, 16'hFF0F);
        rd(15'h0102, 1'b0);
        chk_w(rdat, 16'hAAAA);
    endtask : t_bits

    task automatic t_guard();
        wr(15'h0FFE, 16'h1234, 16'hFFFF);
        wr(15'h2000, 16'h0F0F, 16'hFFFF);
        @(posedge clk_sys_i);
        guard_en_i   <= 1'b1;
        seg_bound1_i <= 3'h1;
        seg_bound2_i <= 3'h2;
        seg0_perm_i  <= PERM_RO;
        seg1_perm_i  <= PERM_RW;
        seg2_perm_i  <= PERM_RX;
        wr(15'h0FFE, 16'h0000, 16'hFFFF);
        chk_b(e, 1'b1);
        chk_lat(lat, 1);
        tick();
        chk_b(viol_flag_o, 1'b1);
        rd(15'h0FFE, 1'b0);
        chk_w(rdat, 16'h1234);
        wr(15'h1000, 16'h5555, 16'hFFFF);
        chk_b(e, 1'b0);
        rd(15'h2000, 1'b1);
        chk_b(e, 1'b0);
        chk_w(rdat, 16'h0F0F);
        rd(15'h1000, 1'b1);
        chk_b(e, 1'b1);
        @(posedge clk_sys_i);
        seg_bound1_i <= 3'h2;
        wr(15'h1000, 16'h0000, 16'hFFFF);
        chk_b(e, 1'b1);
        rd(15'h1000, 1'b0);
        chk_w(rdat, 16'h5555);
        tick();
        chk_b(viol_flag_o, 1'b1);
        @(posedge clk_sys_i);
        viol_clr_i <= 1'b1;
        @(posedge clk_sys_i);
        viol_clr_i <= 1'b0;
        guard_en_i <= 1'b0;
        #1;
        chk_b(viol_flag_o, 1'b0);
    endtask : t_guard

    task automatic t_pwr();
        @(posedge clk_sys_i);
        pwr_fail_i <= 1'b1;
        rd(15'h0100, 1'b0);
        chk_lat(lat, cpu.LAT_CAP);
        @(posedge clk_sys_i);
        pwr_fail_i <= 1'b0;
        // Supply warning lands mid-read; the restore must still finish
        fork
            rd(15'h0100, 1'b0);
            begin
                repeat (6) @(posedge clk_sys_i);
                pwr_fail_i <= 1'b1;
            end
        join
        chk_w(rdat, 16'hFF0F);
        chk_lat(lat, WM + 3);
        @(posedge clk_sys_i);
        pwr_fail_i <= 1'b0;
        rd(15'h0100, 1'b0);
        chk_w(rdat, 16'hFF0F);
    endtask : t_pwr

    // Clock enable low mid-count must stretch the access by exactly that long
    task automatic t_freeze();
        fork
            rd(15'h0100, 1'b0);
            begin
                repeat (3) @(posedge clk_sys_i);
                ce_i <= 1'b0;
                #1;
                chk_b(busy_o, 1'b1);
                repeat (5) @(posedge clk_sys_i);
                ce_i <= 1'b1;
            end
        join
        chk_lat(lat, WM + 8);
        chk_w(rdat, 16'hFF0F);
        chk_b(busy_o, 1'b0);
    endtask : t_freeze

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // Whole run is well under a thousand cycles; this only cuts a hang
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        t_waits();
        t_bits();
        t_guard();
        t_pwr();
        t_freeze();
        test_done();
    end
endmodule : fram_access_controller_test
